// [inc/ipr_pkg.sv]
// Constants for the programming, power and reset control block.
// Assumes an 8-bit special register port driven by the processor core.
package ipr_pkg;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_PROGRAM_CONTROL = 8'hbf;
  localparam logic [7:0] ADDR_PROGRAM_ADDR_LOW = 8'hc4;
  localparam logic [7:0] ADDR_PROGRAM_ADDR_HIGH = 8'hc5;
  localparam logic [7:0] ADDR_PROGRAM_DATA = 8'hc6;
  localparam logic [7:0] ADDR_PROGRAM_COMMAND = 8'hc7;
  localparam logic [7:0] ADDR_WRITE_UNLOCK = 8'hf6;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h30;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_STACK = 8'h07;
  localparam logic [7:0] POWER_KEEP_MASK = 8'h10;
  localparam logic [7:0] PROGRAM_CONTROL_MASK = 8'h93;
  localparam logic [7:0] UNLOCK_FIRST = 8'h87;
  localparam logic [7:0] UNLOCK_SECOND = 8'h59;
  localparam int IDLE_REQUEST_BIT = 0;
  localparam int POWERDOWN_REQUEST_BIT = 1;
  localparam int PROGRAMMING_ENABLE = 0;
  localparam int LOADER_LOCATION_SELECT = 1;
  localparam int SOFTWARE_RESET_REQUEST = 7;
  localparam int TARGET_BANK_SELECT = 6;
  localparam int MEMORY_OUTPUT_ENABLE = 5;
  localparam int MEMORY_CHIP_ENABLE = 4;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_READ = 4'h0;
  // Machine cycle is twelve core clocks; sample at the fifth state
  localparam logic [3:0] MACHINE_CYCLE_CLKS = 4'hc;
  localparam logic [3:0] RESET_SAMPLE_PHASE = 4'h9;
  localparam logic [1:0] RESET_MIN_SAMPLES = 2'h2;
  localparam int MEM_OP_TIME_NS = 40;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [7:0] MEM_OP_CLKS = 8'((MEM_OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [1:0] {
    IPR_RUN = 2'b00,
    IPR_IDLE = 2'b01,
    IPR_BUSY = 2'b10,
    IPR_DOWN = 2'b11
  } ipr_state_e;
endpackage

// [logic/ipr_control.sv]
// Programming sequencer with idle, power-down and reset control.
// Assumes the core writes/reads registers on clk and obeys core_clk_en.
`timescale 1ns/100ps
module ipr_control
  import ipr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reset_pin,
  input wire logic ext_irq_zero_n,
  input wire logic ext_irq_one_n,
  input wire logic ext_irq_zero_en,
  input wire logic ext_irq_one_en,
  input wire logic ext_irq_zero_level,
  input wire logic ext_irq_one_level,
  input wire logic irq_pending,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [7:0] reg_rdata,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic osc_en,
  output logic core_reset,
  output logic [7:0] port_reset_value,
  output logic [7:0] stack_reset_value,
  output logic fetch_from_loader,
  output logic pc_clear,
  output logic loader_return_zero,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_loader_bank,
  output logic [3:0] mem_op,
  output logic mem_output_enable,
  output logic mem_chip_enable,
  output logic mem_strobe
);
  logic rst_s1, rst_s2;
  logic [3:0] phase;
  logic [1:0] rst_count;
  logic ext_reset;
  logic int_reset;
  logic soft_reset;
  logic [7:0] power_control, program_control, addr_low, addr_high, program_data, program_command;
  logic unlock_armed, unlock_open;
  logic prog_mode;
  logic [7:0] op_timer;
  logic [7:0] busy_len;
  ipr_state_e state;
  logic irq0_s1, irq0_s2, irq1_s1, irq1_s2;
  logic wake_down;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = reg_wr && (a == off);
  endfunction

  // Pin crossing, then only the second stage is read
  always_ff @(posedge clk) begin
    rst_s1 <= reset_pin;
    rst_s2 <= rst_s1;
    irq0_s1 <= ext_irq_zero_n;
    irq0_s2 <= irq0_s1;
    irq1_s1 <= ext_irq_one_n;
    irq1_s2 <= irq1_s1;
  end

  // Oscillator stopped means no phase advance in a real part; here clk stays live
  always_ff @(posedge clk) begin
    if (sys_rst || phase == MACHINE_CYCLE_CLKS - 4'h1) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // A glitch between sample points is never seen; a low sample restarts the count
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_count <= 2'h0;
      ext_reset <= 1'b0;
    end else if (phase == RESET_SAMPLE_PHASE) begin
      if (!rst_s2) begin
        rst_count <= 2'h0;
        ext_reset <= 1'b0;
      end else if (rst_count == RESET_MIN_SAMPLES - 2'h1) begin
        ext_reset <= 1'b1;
      end else begin
        rst_count <= rst_count + 2'h1;
      end
    end
  end

  // Bit 4 is the aux memory enable and takes no part in the reset request
  assign soft_reset = program_control[PROGRAMMING_ENABLE] && program_control[LOADER_LOCATION_SELECT] &&
                      program_control[SOFTWARE_RESET_REQUEST];
  assign int_reset = sys_rst || ext_reset || soft_reset;
  assign wake_down = (ext_irq_zero_en && ext_irq_zero_level && !irq0_s2) ||
                     (ext_irq_one_en && ext_irq_one_level && !irq1_s2);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_reset <= 1'b1;
      port_reset_value <= RST_PORT;
      stack_reset_value <= RST_STACK;
    end else begin
      core_reset <= ext_reset || soft_reset;
      port_reset_value <= RST_PORT;
      stack_reset_value <= RST_STACK;
    end
  end

  // Unlock sequence
  always_ff @(posedge clk) begin
    if (int_reset) begin
      unlock_armed <= 1'b0;
      unlock_open <= 1'b0;
    end else if (hit(reg_addr, ADDR_WRITE_UNLOCK)) begin
      unlock_armed <= reg_wdata == UNLOCK_FIRST;
      unlock_open <= unlock_armed && reg_wdata == UNLOCK_SECOND;
    end
  end

  // Registers; bit 4 of power control survives every reset but power-up
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_control <= RST_POWER_CONTROL;
    end else if (ext_reset || soft_reset) begin
      power_control <= power_control & POWER_KEEP_MASK;
    end else if (hit(reg_addr, ADDR_POWER_CONTROL)) begin
      power_control <= reg_wdata;
    end else if (state == IPR_IDLE || state == IPR_BUSY || state == IPR_DOWN) begin
      power_control[IDLE_REQUEST_BIT] <= 1'b0;
      power_control[POWERDOWN_REQUEST_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (int_reset) begin
      program_control <= RST_ZERO;
      addr_low <= RST_ZERO;
      addr_high <= RST_ZERO;
      program_command <= RST_ZERO;
    end else begin
      if (hit(reg_addr, ADDR_PROGRAM_CONTROL) && unlock_open) begin
        program_control <= reg_wdata & PROGRAM_CONTROL_MASK | (reg_wdata & 8'h10);
      end
      if (hit(reg_addr, ADDR_PROGRAM_ADDR_LOW)) begin
        addr_low <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_PROGRAM_ADDR_HIGH)) begin
        addr_high <= reg_wdata;
      end
      if (hit(reg_addr, ADDR_PROGRAM_COMMAND)) begin
        program_command <= reg_wdata;
      end
    end
  end

  // Read data from memory lands in the data register before wake-up
  always_ff @(posedge clk) begin
    if (int_reset) begin
      program_data <= RST_ZERO;
    end else if (state == IPR_BUSY && op_timer == 8'h1 && program_command[3:0] == OP_READ) begin
      program_data <= mem_rdata;
    end else if (hit(reg_addr, ADDR_PROGRAM_DATA)) begin
      program_data <= reg_wdata;
    end
  end

  // Power state machine; operations only ever start from run on an idle request
  always_ff @(posedge clk) begin
    if (int_reset) begin
      state <= IPR_RUN;
      op_timer <= 8'h0;
    end else begin
      case (state)
        IPR_RUN: begin
          if (power_control[POWERDOWN_REQUEST_BIT]) begin
            state <= IPR_DOWN;
          end else if (power_control[IDLE_REQUEST_BIT]) begin
            if (program_control[PROGRAMMING_ENABLE]) begin
              state <= IPR_BUSY;
              op_timer <= MEM_OP_CLKS;
            end else begin
              state <= IPR_IDLE;
            end
          end
        end
        IPR_BUSY: begin
          if (op_timer > 8'h1) begin
            op_timer <= op_timer - 8'h1;
          end else begin
            op_timer <= 8'h0;
            state <= IPR_IDLE;
          end
        end
        IPR_IDLE: begin
          if (irq_pending) begin
            state <= IPR_RUN;
          end
        end
        IPR_DOWN: begin
          if (wake_down) begin
            state <= IPR_RUN;
          end
        end
        default: state <= IPR_RUN;
      endcase
    end
  end

  // Programming mode and memory fetch selection at wake-up
  always_ff @(posedge clk) begin
    if (int_reset) begin
      prog_mode <= 1'b0;
      fetch_from_loader <= 1'b0;
      pc_clear <= 1'b0;
      loader_return_zero <= 1'b0;
    end else begin
      pc_clear <= 1'b0;
      if (state == IPR_IDLE && irq_pending) begin
        prog_mode <= program_control[PROGRAMMING_ENABLE];
        if (program_control[PROGRAMMING_ENABLE] && program_control[LOADER_LOCATION_SELECT]
            && !prog_mode) begin
          fetch_from_loader <= 1'b1;
          pc_clear <= 1'b1;
          loader_return_zero <= 1'b1;
        end
      end else if (hit(reg_addr, ADDR_PROGRAM_CONTROL) && unlock_open) begin
        loader_return_zero <= loader_return_zero;
      end
    end
  end

  // Memory port registered every cycle; chip enable only during the busy window
  always_ff @(posedge clk) begin
    if (int_reset) begin
      mem_addr <= 16'h0;
      mem_wdata <= RST_ZERO;
      mem_loader_bank <= 1'b0;
      mem_op <= 4'h0;
      mem_output_enable <= 1'b0;
      mem_chip_enable <= 1'b0;
      mem_strobe <= 1'b0;
    end else begin
      mem_addr <= {addr_high, addr_low};
      mem_wdata <= program_data;
      mem_loader_bank <= program_command[TARGET_BANK_SELECT];
      mem_op <= program_command[3:0];
      mem_output_enable <= program_command[3:0] == OP_ERASE || program_command[3:0] == OP_PROGRAM;
      mem_chip_enable <= state == IPR_BUSY;
      mem_strobe <= state == IPR_RUN && power_control[IDLE_REQUEST_BIT] &&
                    program_control[PROGRAMMING_ENABLE] && !power_control[POWERDOWN_REQUEST_BIT];
    end
  end

  // Clock gates
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
    end else begin
      core_clk_en <= int_reset || !(state == IPR_IDLE || state == IPR_BUSY || state == IPR_DOWN);
      periph_clk_en <= int_reset || state != IPR_DOWN;
      osc_en <= int_reset || state != IPR_DOWN;
    end
  end

  // Write-only unlock reads as zero; unmapped reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= RST_ZERO;
    end else begin
      case (reg_addr)
        ADDR_POWER_CONTROL: reg_rdata <= power_control;
        ADDR_PROGRAM_CONTROL: reg_rdata <= program_control;
        ADDR_PROGRAM_ADDR_LOW: reg_rdata <= addr_low;
        ADDR_PROGRAM_ADDR_HIGH: reg_rdata <= addr_high;
        ADDR_PROGRAM_DATA: reg_rdata <= program_data;
        ADDR_PROGRAM_COMMAND: reg_rdata <= program_command;
        default: reg_rdata <= RST_ZERO;
      endcase
    end
  end

  // Busy length counter for the check below; cheaper than a long repetition
  always_ff @(posedge clk) begin
    if (int_reset || state != IPR_BUSY) begin
      busy_len <= 8'h0;
    end else begin
      busy_len <= busy_len + 8'h1;
    end
  end

  a_unlock_order: assert property (@(posedge clk) disable iff (int_reset)
    hit(reg_addr, ADDR_WRITE_UNLOCK) && reg_wdata != UNLOCK_FIRST && reg_wdata != UNLOCK_SECOND
    |=> !unlock_open) else $error("unlock kept after bad value");
  a_locked_write: assert property (@(posedge clk) disable iff (int_reset)
    hit(reg_addr, ADDR_PROGRAM_CONTROL) && !unlock_open |=> $stable(program_control))
    else $error("locked program control changed");
  a_idle_gate: assert property (@(posedge clk) disable iff (int_reset)
    state == IPR_IDLE |=> !core_clk_en) else $error("core clock on in idle");
  a_down_osc: assert property (@(posedge clk) disable iff (int_reset)
    state == IPR_DOWN |=> !osc_en && !periph_clk_en) else $error("clocks on in power-down");
  a_idle_wake: assert property (@(posedge clk) disable iff (int_reset)
    state == IPR_IDLE && irq_pending |=> state == IPR_RUN ##1 core_clk_en)
    else $error("no wake from idle");
  a_down_exit: assert property (@(posedge clk) disable iff (int_reset)
    state == IPR_DOWN && !wake_down |=> state == IPR_DOWN) else $error("power-down left early");
  a_busy_in_idle: assert property (@(posedge clk) disable iff (int_reset)
    mem_chip_enable |-> !core_clk_en) else $error("operation outside idle");
  a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst)
    soft_reset |=> core_reset ##1 program_control == RST_ZERO) else $error("soft reset missing");
  a_busy_length: assert property (@(posedge clk) disable iff (int_reset)
    state == IPR_BUSY ##1 state != IPR_BUSY |-> state == IPR_IDLE && busy_len == MEM_OP_CLKS)
    else $error("operation length wrong");
  a_addr_form: assert property (@(posedge clk) disable iff (int_reset)
    mem_chip_enable && $stable(addr_high) && $stable(addr_low) |-> mem_addr == {addr_high, addr_low})
    else $error("address bytes swapped");
  c_unlock: cover property (@(posedge clk) unlock_open);
  c_loader_switch: cover property (@(posedge clk) pc_clear);
  c_busy: cover property (@(posedge clk) state == IPR_BUSY);
  c_down_wake: cover property (@(posedge clk) state == IPR_DOWN ##1 state == IPR_RUN);
  c_soft: cover property (@(posedge clk) soft_reset);
endmodule // ipr_control

// [tb/ipr_core_model.sv]
// Core and program memory model: register writes/reads, interrupt request, read data.
// Assumes one clk shared with the block; inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
module ipr_core_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_chip_enable,
  input wire logic [7:0] reg_rdata,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic irq_pending,
  output logic [7:0] mem_rdata
);
  logic [7:0] idle_pattern = 8'h00;
  initial begin
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    irq_pending = 1'b0;
  end
  // Deselected memory shows a moving pattern, so a stale byte never matches
  always_ff @(posedge clk) idle_pattern <= idle_pattern + 8'h3b;
  assign mem_rdata = mem_chip_enable ? (mem_addr[7:0] ^ 8'h5a) : idle_pattern;
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    @(posedge clk);
    #1;
    d = reg_rdata;
  endtask
  task automatic unlock();
    write_reg(8'hf6, 8'h87);
    write_reg(8'hf6, 8'h59);
  endtask
  // Timer-style wake so an operation has finished first
  task automatic timed_wake(input int wait_clks);
    repeat (wait_clks) @(posedge clk);
    #1;
    irq_pending = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    irq_pending = 1'b0;
  endtask
endmodule // ipr_core_model

// [tb/isp_power_reset_control_tb.sv]
// Testbench for the programming, power and reset control block.
// Assumes the core model above and the design package constants.
`timescale 1ns/100ps
module isp_power_reset_control_tb;
  import ipr_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, reset_pin = 1'b0, irq0_n = 1'b1, irq0_level = 1'b0;
  logic irq0_en = 1'b1, irq1_n = 1'b1, irq1_en = 1'b0, irq1_level = 1'b1;
  logic reg_wr, irq_pending, core_clk_en, periph_clk_en, osc_en, core_reset, fetch_from_loader;
  logic pc_clear, loader_return_zero, mem_loader_bank, mem_output_enable, mem_chip_enable, mem_strobe;
  logic [7:0] reg_addr, reg_wdata, mem_rdata, reg_rdata, port_reset_value, stack_reset_value, mem_wdata;
  logic [15:0] mem_addr;
  logic [3:0] mem_op;
  int errors = 0, checked = 0, pc_pulses = 0;
  logic [7:0] rst_addr [8] = '{8'h87, 8'hbf, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hf6, 8'h80};
  logic [7:0] rst_val [8] = '{8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [3:0] ops [3] = '{OP_ERASE, OP_PROGRAM, OP_READ};
  always #2 clk = ~clk;
  // Counts one-cycle wake pulses that a polled check could miss
  always @(posedge clk) begin
    if (pc_clear === 1'b1) pc_pulses++;
  end
  ipr_core_model u_core (.clk(clk), .mem_addr(mem_addr), .mem_chip_enable(mem_chip_enable),
    .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .irq_pending(irq_pending), .mem_rdata(mem_rdata));
  ipr_control u_dut (.clk(clk), .sys_rst(sys_rst), .reset_pin(reset_pin), .ext_irq_zero_n(irq0_n),
    .ext_irq_one_n(irq1_n), .ext_irq_zero_en(irq0_en), .ext_irq_one_en(irq1_en), .ext_irq_zero_level(irq0_level),
    .ext_irq_one_level(irq1_level), .irq_pending(irq_pending), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .mem_rdata(mem_rdata), .reg_rdata(reg_rdata), .core_clk_en(core_clk_en),
    .periph_clk_en(periph_clk_en), .osc_en(osc_en), .core_reset(core_reset),
    .port_reset_value(port_reset_value), .stack_reset_value(stack_reset_value),
    .fetch_from_loader(fetch_from_loader), .pc_clear(pc_clear), .loader_return_zero(loader_return_zero),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_loader_bank(mem_loader_bank), .mem_op(mem_op),
    .mem_output_enable(mem_output_enable), .mem_chip_enable(mem_chip_enable), .mem_strobe(mem_strobe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Bounded wait: 0 strobe, 1 programming wake, 2 core reset, 3 core clock running
  task automatic wait_sig(input int sel);
    for (int n = 0; n < 40; n++) begin
      if ((sel == 0 && mem_strobe === 1'b1) || (sel == 1 && pc_clear === 1'b1) ||
          (sel == 2 && core_reset === 1'b1) || (sel == 3 && core_clk_en === 1'b1)) break;
      @(posedge clk);
      #1;
    end
  endtask
  task automatic pin_pulse(input int len, output logic seen);
    seen = 1'b0;
    for (int k = 0; k < 60; k++) begin
      reset_pin = (k < len);
      @(posedge clk);
      #1;
      seen = seen | (core_reset === 1'b1);
    end
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #40000;
    errors++;
    results();
  end
  initial begin
    logic [7:0] d;
    logic seen;
    repeat (12) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      u_core.read_reg(rst_addr[i], d);
      chk(16'(d), 16'(rst_val[i]), "register reset value");
    end
    // Plain idle, no programming enabled
    u_core.write_reg(ADDR_POWER_CONTROL, 8'h11);
    @(posedge clk);
    #1;
    @(posedge clk);
    #1;
    chk(16'({core_clk_en, periph_clk_en}), 16'h1, "idle clock gates");
    u_core.timed_wake(2);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(core_clk_en), 16'h1, "idle wake by interrupt");
    // Power-down ignores ordinary and edge-type interrupts
    u_core.write_reg(ADDR_POWER_CONTROL, 8'h12);
    repeat (3) @(posedge clk);
    #1;
    chk(16'({osc_en, periph_clk_en, core_clk_en}), 16'h0, "power-down gates");
    u_core.timed_wake(1);
    irq0_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(16'(core_clk_en), 16'h0, "power-down held against edge irq");
    irq0_level = 1'b1;
    wait_sig(3);
    chk(16'({osc_en, core_clk_en}), 16'h3, "power-down wake by level irq");
    irq0_n = 1'b1;
    // Disabled irq zero leaves it asleep; enabled level irq one wakes it
    irq0_en = 1'b0;
    irq1_en = 1'b1;
    u_core.write_reg(ADDR_POWER_CONTROL, 8'h12);
    irq0_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    chk(16'(core_clk_en), 16'h0, "disabled irq zero ignored");
    irq1_n = 1'b0;
    wait_sig(3);
    chk(16'({osc_en, core_clk_en}), 16'h3, "power-down wake by irq one");
    irq0_n = 1'b1;
    irq1_n = 1'b1;
    // Write permission of program control
    u_core.write_reg(ADDR_PROGRAM_CONTROL, 8'h01);
    u_core.read_reg(ADDR_PROGRAM_CONTROL, d);
    chk(16'(d), 16'h0, "locked write dropped");
    u_core.unlock();
    u_core.write_reg(ADDR_PROGRAM_CONTROL, 8'h01);
    u_core.read_reg(ADDR_PROGRAM_CONTROL, d);
    chk(16'(d), 16'h1, "unlocked write stored");
    u_core.write_reg(ADDR_WRITE_UNLOCK, 8'h00);
    u_core.write_reg(ADDR_PROGRAM_CONTROL, 8'h00);
    u_core.read_reg(ADDR_PROGRAM_CONTROL, d);
    chk(16'(d), 16'h1, "other unlock value locks");
    u_core.write_reg(ADDR_WRITE_UNLOCK, 8'h59);
    u_core.write_reg(ADDR_WRITE_UNLOCK, 8'h87);
    u_core.write_reg(ADDR_PROGRAM_CONTROL, 8'h00);
    u_core.read_reg(ADDR_PROGRAM_CONTROL, d);
    chk(16'(d), 16'h1, "reversed unlock order refused");
    // Each operation launched by idle entry; loader runs from loader memory
    u_core.unlock();
    u_core.write_reg(ADDR_PROGRAM_CONTROL, 8'h03);
    for (int i = 0; i < 3; i++) begin
      u_core.write_reg(ADDR_PROGRAM_ADDR_HIGH, 8'h12 + 8'(i));
      u_core.write_reg(ADDR_PROGRAM_ADDR_LOW, 8'h34);
      u_core.write_reg(ADDR_PROGRAM_DATA, 8'hc3);
      u_core.write_reg(ADDR_PROGRAM_COMMAND, {1'b0, 1'(i), ops[i] != OP_READ, 1'b0, ops[i]});
      u_core.read_reg(ADDR_PROGRAM_COMMAND, d);
      chk(16'(d), 16'({1'b0, 1'(i), ops[i] != OP_READ, 1'b0, ops[i]}), "command held");
      u_core.write_reg(ADDR_POWER_CONTROL, 8'h11);
      wait_sig(0);
      chk(16'(mem_strobe), 16'h1, "launch on idle entry");
      @(posedge clk);
      #1;
      chk(16'({mem_chip_enable, core_clk_en}), 16'h2, "operation while idle");
      chk(mem_addr, {8'h12 + 8'(i), 8'h34}, "target address");
      chk(16'({mem_loader_bank, mem_op}), 16'({1'(i), ops[i]}), "bank and opcode");
      chk(16'(mem_output_enable), 16'(ops[i] != OP_READ), "output enable");
      if (ops[i] == OP_PROGRAM) chk(16'(mem_wdata), 16'hc3, "program data");
      u_core.timed_wake(16);
      chk(16'(pc_pulses), 16'h1, "program counter cleared once at switch");
      @(posedge clk);
      #1;
      chk(16'({fetch_from_loader, loader_return_zero}), 16'h3, "run from loader");
      if (ops[i] == OP_READ) begin
        u_core.read_reg(ADDR_PROGRAM_DATA, d);
        chk(16'(d), 16'(8'h34 ^ 8'h5a), "read data returned");
      end
    end
    u_core.write_reg(ADDR_POWER_CONTROL, 8'hf0);
    u_core.unlock();
    u_core.write_reg(ADDR_PROGRAM_CONTROL, 8'h83);
    wait_sig(2);
    chk(16'(core_reset), 16'h1, "software reset");
    repeat (40) @(posedge clk);
    u_core.read_reg(ADDR_POWER_CONTROL, d);
    chk(16'(d), 16'h10, "bit 4 kept");
    u_core.read_reg(ADDR_PROGRAM_CONTROL, d);
    chk(16'(d), 16'h0, "program control cleared");
    pin_pulse(5, seen);
    chk(16'(seen), 16'h0, "glitch ignored");
    pin_pulse(30, seen);
    chk(16'(seen), 16'h1, "pin reset taken");
    chk(16'({port_reset_value, stack_reset_value}), 16'hff07, "port and stack values");
    results();
  end
endmodule // isp_power_reset_control_tb
